/* design/dol_output_latch.sv */
// Double-buffered storage and output latches for eight converter channels
// -------------------------------------------------------------------------
// -------------------------------------------------------------------------
module dol_output_latch
  import dol_pkg::*;
(
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_i,
  input  wire logic                      gc_reset_i,
  input  wire logic                      latch_strobe_pin_i,
  input  wire dol_wr_s                   wr_i,
  output dol_code_t [DOL_NUM_CH-1:0]     out_code_o,
  output dol_code_t [DOL_NUM_CH-1:0]     store_code_o,
  output logic                           load_pulse_o
);

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  // Extract the converter code; trigger and spare upper bits are dropped
  function automatic dol_code_t word_code(input logic [DOL_WORD_W-1:0] w);
    word_code = w[DOL_CODE_MSB:0];
  endfunction

  // Channel select decode, used for storage and latch paths
  function automatic logic ch_hit(input logic [DOL_CH_AW-1:0] a,
                                  input int unsigned ch);
    ch_hit = (a == DOL_CH_AW'(ch));
  endfunction

  // -----------------------------------------------------------------------
  // Strobe pin synchronisation and edge detection
  // -----------------------------------------------------------------------
  logic strobe_s;
  logic strobe_dly_q;
  logic strobe_fall;

  dol_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .d_i       (latch_strobe_pin_i),
    .q_o       (strobe_s)
  );

  // Delayed copy for falling edge; only the synchronised level is used
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      strobe_dly_q <= 1'b1;
    else
      strobe_dly_q <= strobe_s;
  end

  assign strobe_fall = strobe_dly_q & ~strobe_s;

  // -----------------------------------------------------------------------
  // Storage registers
  // -----------------------------------------------------------------------
  dol_code_t [DOL_NUM_CH-1:0] store_q;
  dol_code_t [DOL_NUM_CH-1:0] store_d;
  logic                       soft_trig;

  // Serial slave only strobes after both bytes, so aborted words never land
  assign soft_trig = wr_i.strobe & wr_i.word[DOL_TRIG_BIT];

  // Next storage contents include the word landing this cycle
  always_comb
  begin
    store_d = store_q;
    for (int i = 0; i < DOL_NUM_CH; i++)
    begin
      if (wr_i.strobe && ch_hit(wr_i.chan, i))
        store_d[i] = word_code(wr_i.word);
    end
  end

  // Storage bank; general-call reset restores mid-scale
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      store_q <= {DOL_NUM_CH{DOL_CODE_MID}};
    else if (gc_reset_i)
      store_q <= {DOL_NUM_CH{DOL_CODE_MID}};
    else
      store_q <= store_d;
  end

  // -----------------------------------------------------------------------
  // Output latches
  // -----------------------------------------------------------------------
  dol_load_e load_kind;

  // Global loads win over a single-channel follow load
  always_comb
  begin
    if (soft_trig || strobe_fall)
      load_kind = DOL_LD_ALL;
    else if (wr_i.strobe && !strobe_s)
      load_kind = DOL_LD_ONE;
    else
      load_kind = DOL_LD_NONE;
  end

  // Per-channel latch; loads from store_d so a trigger word counts itself
  generate
    for (genvar g = 0; g < DOL_NUM_CH; g++)
    begin : g_latch
      always_ff @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
          out_code_o[g] <= DOL_CODE_MID;
        else if (gc_reset_i)
          out_code_o[g] <= DOL_CODE_MID;
        else
        begin
          case (load_kind)
            DOL_LD_ALL: out_code_o[g] <= store_d[g];
            DOL_LD_ONE:
              if (ch_hit(wr_i.chan, g))
                out_code_o[g] <= store_d[g];
            DOL_LD_NONE: out_code_o[g] <= out_code_o[g];
            default: out_code_o[g] <= out_code_o[g];
          endcase
        end
      end
    end
  endgenerate

  // Storage readback for the serial read path
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      store_code_o <= {DOL_NUM_CH{DOL_CODE_MID}};
    else
      store_code_o <= gc_reset_i ? {DOL_NUM_CH{DOL_CODE_MID}} : store_d;
  end

  // Pulse marking any latch update, for observation
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      load_pulse_o <= 1'b0;
    else
      load_pulse_o <= gc_reset_i | (load_kind != DOL_LD_NONE);
  end

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  a_hold_strobe_high:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (strobe_s && !strobe_fall && !soft_trig && !gc_reset_i)
        |=> $stable(out_code_o))
    else $error("Latches changed while strobe held high");

  a_follow_low:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr_i.strobe && !strobe_s && !gc_reset_i && wr_i.chan == DOL_CH_COM)
        |=> out_code_o[0] == $past(wr_i.word[DOL_CODE_MSB:0]))
    else $error("Common channel did not follow write with strobe low");

  a_fall_loads_all:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (strobe_fall && !gc_reset_i && !wr_i.strobe) |=> out_code_o == store_q)
    else $error("Strobe fall did not load every latch");

  a_soft_trigger:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (soft_trig && !gc_reset_i) |=> (out_code_o == store_q) && load_pulse_o)
    else $error("Trigger bit did not load all latches");

  a_storage_isolated:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr_i.strobe && strobe_s && !strobe_dly_q == 1'b0 && !soft_trig
       && !gc_reset_i) |=> $stable(out_code_o))
    else $error("Storage write leaked to output");

  a_gc_midscale:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      gc_reset_i |=> out_code_o == {DOL_NUM_CH{DOL_CODE_MID}}
                     && store_q == {DOL_NUM_CH{DOL_CODE_MID}})
    else $error("General reset did not restore mid-scale");

  a_no_strobe_keep:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!wr_i.strobe && !gc_reset_i) |=> $stable(store_q))
    else $error("Storage changed without completed word");

  a_code_width:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr_i.strobe && !gc_reset_i && wr_i.chan == DOL_CH_COM)
        |=> store_q[0] == $past(wr_i.word[DOL_CODE_MSB:0]))
    else $error("Stored code not taken from low ten bits");

  // A follow load must also be flagged, or the observer misses it
  a_pulse_follow:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr_i.strobe && !strobe_s && !gc_reset_i)
        |=> load_pulse_o)
    else $error("Follow load not flagged by load pulse");

  a_trig_self:
    assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (soft_trig && !gc_reset_i && wr_i.chan == DOL_CH_COM)
        |=> out_code_o[0] == $past(wr_i.word[DOL_CODE_MSB:0]))
    else $error("Trigger word not latched without its trigger bit");

endmodule // dol_output_latch

/* design/dol_pkg.sv */
// Package: constants and carrier types for the output latch control block
package dol_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int unsigned DOL_NUM_CH    = 8;
  localparam int unsigned DOL_CH_AW     = 3;
  localparam int unsigned DOL_CODE_W    = 10;
  localparam int unsigned DOL_WORD_W    = 16;

  // ----------------------------------------------------------------------
  // Field positions in a written word
  // ----------------------------------------------------------------------
  localparam int unsigned DOL_TRIG_BIT  = 15;
  localparam int unsigned DOL_CODE_MSB  = 9;

  // ----------------------------------------------------------------------
  // Reset and code values
  // ----------------------------------------------------------------------
  localparam logic [9:0]  DOL_CODE_MID  = 10'h200;
  localparam logic [9:0]  DOL_CODE_MIN  = 10'h000;
  localparam logic [9:0]  DOL_CODE_MAX  = 10'h3ff;
  localparam logic [2:0]  DOL_CH_COM    = 3'h0;

  typedef logic [DOL_CODE_W-1:0] dol_code_t;

  // Completed write from the serial slave
  typedef struct packed {
    logic                 strobe;
    logic [DOL_CH_AW-1:0] chan;
    logic [DOL_WORD_W-1:0] word;
  } dol_wr_s;

  // Cause of an output latch load
  typedef enum logic [1:0] {
    DOL_LD_NONE,
    DOL_LD_ONE,
    DOL_LD_ALL
  } dol_load_e;

endpackage : dol_pkg

/* design/dol_sync.sv */
// Two-stage level synchroniser for the latch strobe pin
module dol_sync
  import dol_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_q;

  // Reset high: pin idles high so no spurious fall is seen after reset
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b1;
      q_o    <= 1'b1;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule // dol_sync

/* verif/dol_ctrl_model.sv */
// Behavioural controller model driving word strobes and the latch pin
module dol_ctrl_model
  import dol_pkg::*;
(
  input  wire logic clk_sys_i,
  output dol_wr_s   wr_o,
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle with pin high so nothing latches before data is ready
  initial
  begin
    wr_o  = '0;
    pin_o = 1'b1;
  end

  // Whole words only; idle fields flip so stale data never looks valid
  task automatic put_word(logic [2:0] ch, logic [15:0] w, logic last);
    wr_o = '{strobe: 1'b1, chan: ch, word: w};
    @(posedge clk_sys_i);
    #1;
    if (last)
      wr_o = '{strobe: 1'b0, chan: ~ch, word: ~w};
  endtask

  // Pin held high for preload and software trigger
  task automatic set_pin(logic v);
    pin_o = v;
  endtask
endmodule // dol_ctrl_model

/* verif/dol_output_latch_test.sv */
// Self-checking bench for the output latch control block
module dol_output_latch_test
  import dol_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                       clk_sys_i;
  logic                       rst_i;
  logic                       gc_reset_i;
  logic                       load_pulse;
  logic                       pin;
  dol_wr_s                    wr;
  dol_code_t [DOL_NUM_CH-1:0] out_code, store_code, st, oc;
  dol_code_t [DOL_NUM_CH-1:0] notes[$];
  int                         error_cnt = 0;
  int                         compares = 0;

  dol_ctrl_model pm (.clk_sys_i(clk_sys_i), .wr_o(wr), .pin_o(pin));

  dol_output_latch dut (
    .clk_sys_i          (clk_sys_i),
    .rst_i              (rst_i),
    .gc_reset_i         (gc_reset_i),
    .latch_strobe_pin_i (pin),
    .wr_i               (wr),
    .out_code_o         (out_code),
    .store_code_o       (store_code),
    .load_pulse_o       (load_pulse)
  );

  // ------------------------------------------------------------------
  // Clock, checks and closing
  // ------------------------------------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(string nm, logic [79:0] e, logic [79:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic step(int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // Write one word; note the latch contents expected if a load follows
  task automatic put(logic [2:0] ch, logic trig, dol_code_t code, logic last);
    logic [15:0] w;
    w = {trig, 5'($urandom), code};
    st[ch] = code;
    if (!pin)
      oc[ch] = code;
    if (trig)
      oc = st;
    if (!pin || trig)
      notes.push_back(oc);
    pm.put_word(ch, w, last);
  endtask

  // Latched codes are compared in the cycle of each load pulse; a pulse with no note counts as an error
  always @(negedge clk_sys_i)
    if (load_pulse !== 1'b0)
    begin
      if (notes.size() > 0)
        check("latched codes", notes.pop_front(), out_code);
      else
        check("load pulse", 80'(0), 80'(load_pulse));
    end

  // Hang guard, far beyond the roughly fifty cycles the run needs
  initial
  begin
    #100us;
    error_cnt++;
    finish_test();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    rst_i = 1'b1;
    gc_reset_i = 1'b0;
    void'($urandom(32'hea289c7d));
    st = {DOL_NUM_CH{DOL_CODE_MID}};
    oc = st;
    step(10);
    rst_i = 1'b0;
    check("reset out", oc, out_code);
    // Pin high: every channel written, outputs must not move
    for (int i = 0; i < 8; i++)
      put(i[2:0], 1'b0, 10'($urandom), i == 7);
    step(1);
    check("store", st, store_code);
    check("held out", oc, out_code);
    // Pin falls: nothing yet after one edge, then all load together
    pm.set_pin(1'b0);
    step(1);
    check("sync delay", oc, out_code);
    oc = st;
    notes.push_back(oc);
    step(4);
    // Pin low, back to back, common channel at both extremes
    put(3'h0, 1'b0, DOL_CODE_MIN, 1'b0);
    put(3'h0, 1'b0, DOL_CODE_MAX, 1'b0);
    for (int i = 1; i < 8; i++)
      put(i[2:0], 1'b0, 10'($urandom), i == 7);
    step(2);
    check("store low", st, store_code);
    // Software trigger with the pin held high
    pm.set_pin(1'b1);
    step(4);
    put(3'h1, 1'b0, 10'($urandom), 1'b0);
    put(3'h0, 1'b1, 10'($urandom), 1'b1);
    step(2);
    check("trig out", oc, out_code);
    // General reset with the pin high wins over a write in the same cycle
    notes.push_back({DOL_NUM_CH{DOL_CODE_MID}});
    gc_reset_i = 1'b1;
    put(3'h3, 1'b0, 10'($urandom), 1'b1);
    gc_reset_i = 1'b0;
    st = {DOL_NUM_CH{DOL_CODE_MID}};
    oc = st;
    check("gc out", st, out_code);
    check("gc store", st, store_code);
    step(3);
    check("notes left", 80'(0), 80'(notes.size()));
    finish_test();
  end
endmodule // dol_output_latch_test
